// file: hw/spi_cfg_device.sv
// Device end: frame decoder, register storage and read-back driver
// Function
// RULE_01: Four-wire or three-wire shared data pin wiring.
// RULE_02: Each write frame is exactly 24 bits.
// RULE_03: First bit selects read or write.
// RULE_04: Next fifteen bits select the register.
// RULE_05: Write stores the final eight bits.
// RULE_06: Host drives first sixteen read bits shared.
// RULE_07: Device returns read byte on selected pin.
// RULE_08: Host pulses device reset before any frame.
// RULE_09: Active-low select, MSB first, one means read.
// RULE_10: Shared pin released except during read byte.
`timescale 1ns/1ns
module spi_cfg_device
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Wiring option
    input  wire logic                          threeWire,
    // Register contents for the device logic
    output logic [NUM_REGS*DATA_BITS-1:0]      regFlat,
    // Write notification
    output logic                               wrPulse,
    output logic [ADDR_BITS-1:0]               wrAddr,
    output logic [DATA_BITS-1:0]               wrData,
    // Link
    spi_cfg_link.dev_mp                        link
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                  rst;            // Local reset or host reset pulse
    logic                  sclkPrev_q;     // Serial clock of last cycle
    logic                  sclkRise;       // Rising serial edge seen
    logic                  sclkFall;       // Falling serial edge seen
    logic                  inFrame;        // Select is low
    logic [4:0]            bitCnt_q;       // Bits received in this frame
    logic [FRAME_BITS-2:0] inShift_q;      // Bits received so far
    logic [FRAME_BITS-1:0] frameNext;      // Frame including the bit now sampled
    logic [DATA_BITS-1:0]  outShift_q;     // Read byte being shifted out
    logic                  readActive_q;   // Read byte is being driven
    logic                  headRead;       // Header says read
    logic [ADDR_BITS-1:0]  headAddr;       // Header address
    logic                  addrHit;        // Address inside the storage
    logic [DATA_BITS-1:0]  readByte;       // Addressed register value
    logic [DATA_BITS-1:0]  regs_q [NUM_REGS]; // Register storage
    logic                  wrHit;          // Final write bit with a valid address
    logic [ADDR_BITS-1:0]  frameAddr;      // Address of the completed frame
    logic [DATA_BITS-1:0]  frameData;      // Data byte of the completed frame

    ////////////////////////////////////////////////////////////////////////////
    // Reset: local reset or the pulse the host gives before configuring
    assign rst = reset || link.cfgReset; // [RULE_08]

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the host clock, pins are synchronous here
    assign inFrame  = !link.csN; // [RULE_09]
    assign sclkRise = inFrame && link.sclk && !sclkPrev_q;
    assign sclkFall = inFrame && !link.sclk && sclkPrev_q;

    // Previous serial clock level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= link.sclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Header decode
    // Both options take host bits on the shared pin
    assign frameNext = {inShift_q, link.dioLevel}; // [RULE_06] [RULE_09]
    // Direction sits in the first bit, one means read
    assign headRead  = (inShift_q[HEAD_BITS-1] == DIR_READ); // [RULE_03] [RULE_09]
    // Fifteen address bits follow the direction bit
    assign headAddr  = inShift_q[ADDR_BITS-1:0]; // [RULE_04]
    // Addresses above the storage read as zero and drop writes
    assign addrHit   = (headAddr < ADDR_BITS'(NUM_REGS));
    assign readByte  = addrHit ? regs_q[headAddr[REG_IDX_BITS-1:0]] : 8'h00; // [RULE_04]

    // Completed frame fields at the last rising edge
    assign frameAddr = frameNext[FRAME_BITS-2:DATA_BITS];
    assign frameData = frameNext[DATA_BITS-1:0]; // [RULE_05]
    assign wrHit     = sclkRise && (bitCnt_q == CNT_LAST_BIT)
                       && (frameNext[DIR_POS] == DIR_WRITE)
                       && (frameAddr < ADDR_BITS'(NUM_REGS)); // [RULE_02] [RULE_03]

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter and input shift, cleared whenever select is high
    always_ff @(posedge ref_clk) begin
        if (rst || !inFrame) begin
            bitCnt_q  <= 5'h00;
            inShift_q <= '0;
        end else if (sclkRise && bitCnt_q != CNT_FRAME_DONE) begin
            // Bits beyond the 24th are ignored
            bitCnt_q  <= bitCnt_q + 5'h01; // [RULE_02]
            inShift_q <= frameNext[FRAME_BITS-2:0]; // [RULE_09]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage, one entry per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            // Store the data byte in the addressed entry
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    regs_q[gi] <= REG_RESET;
                end else if (wrHit && frameAddr[REG_IDX_BITS-1:0] == REG_IDX_BITS'(gi)) begin
                    regs_q[gi] <= frameData; // [RULE_05]
                end
            end
            // Contents to the device logic straight from storage
            assign regFlat[gi*DATA_BITS +: DATA_BITS] = regs_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Write notification for the device logic, one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPulse <= 1'b0;
            wrAddr  <= '0;
            wrData  <= '0;
        end else begin
            wrPulse <= wrHit;
            if (wrHit) begin
                wrAddr <= frameAddr;
                wrData <= frameData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back shifter
    // Loaded on the fall after the header, so the host has let go of the pin
    always_ff @(posedge ref_clk) begin
        if (rst || !inFrame) begin
            outShift_q   <= '0;
            readActive_q <= 1'b0;
        end else if (sclkFall && bitCnt_q == CNT_HEAD_DONE && headRead) begin
            // Most significant data bit first
            outShift_q   <= readByte; // [RULE_07] [RULE_09]
            readActive_q <= 1'b1;
        end else if (sclkFall && readActive_q) begin
            // Next bit for the next rising edge
            outShift_q <= {outShift_q[DATA_BITS-2:0], 1'b0}; // [RULE_07]
        end else if (sclkRise && bitCnt_q == CNT_LAST_BIT) begin
            // Last read bit sampled, stop driving
            readActive_q <= 1'b0; // [RULE_10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, taken from flops to keep the outputs glitch-free
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.sdo      <= 1'b0;
            link.devDio   <= 1'b0;
            link.devDioOe <= 1'b0;
        end else begin
            // Dedicated output carries read data in four-wire wiring
            if (!threeWire) begin
                link.sdo <= readActive_q ? outShift_q[DATA_BITS-1] : 1'b0; // [RULE_01] [RULE_07]
            end else begin
                link.sdo <= 1'b0;
            end
            // Shared pin only while the read byte is out, in three-wire wiring
            link.devDio   <= outShift_q[DATA_BITS-1]; // [RULE_07]
            link.devDioOe <= threeWire && readActive_q && inFrame; // [RULE_01] [RULE_10]
        end
    end

endmodule

// file: hw/spi_cfg_host.sv
// Host end: resets the device, then frames register reads and writes
`timescale 1ns/1ns
module spi_cfg_host
    import spi_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Wiring option
    input  wire logic                 threeWire,
    // Request side
    input  wire logic                 reqValid,
    input  wire logic                 reqRead,
    input  wire logic [ADDR_BITS-1:0] reqAddr,
    input  wire logic [DATA_BITS-1:0] reqData,
    output logic                      reqReady,
    // Answer side
    output logic                      rspValid,
    output logic [DATA_BITS-1:0]      rspData,
    // Link
    spi_cfg_link.host_mp              link
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    host_state_type        state_q;      // Sequencer state
    logic [7:0]            divCnt_q;     // Half-period divider
    logic                  tick;         // One-cycle half-period enable
    logic [7:0]            waitCnt_q;    // Reset pulse and settle counter
    logic [5:0]            half_q;       // Half-period index in frame
    logic [FRAME_BITS-1:0] txShift_q;    // Outgoing frame
    logic [DATA_BITS-1:0]  rxShift_q;    // Incoming read byte
    logic                  isRead_q;     // Frame is a read
    logic                  readBit;      // Read data from the selected pin

    ////////////////////////////////////////////////////////////////////////////
    // Divider: tick every serial half period while framing
    assign tick = (divCnt_q == 8'(SCLK_HALF_CYC - 1));

    // Free-running counter held at zero in H_IDLE
    always_ff @(posedge ref_clk) begin
        if (reset || state_q == H_IDLE || tick) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    // Read bits arrive on the shared pin or the dedicated output
    assign readBit = threeWire ? link.dioLevel : link.sdo; // [RULE_01] [RULE_07]

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q       <= H_RESET;
            waitCnt_q     <= 8'h00;
            half_q        <= 6'h00;
            txShift_q     <= '0;
            rxShift_q     <= '0;
            isRead_q      <= 1'b0;
            link.csN      <= 1'b1;
            link.sclk     <= 1'b0;
            link.hostDio  <= 1'b0;
            link.hostDioOe<= 1'b0;
            link.cfgReset <= 1'b1;
            reqReady      <= 1'b0;
            rspValid      <= 1'b0;
            rspData       <= '0;
        end else begin
            rspValid <= 1'b0;
            case (state_q)
                // Hold the device in reset for the pulse width
                H_RESET: begin
                    waitCnt_q <= waitCnt_q + 8'h01;
                    if (waitCnt_q == 8'(RST_PULSE_CYC - 1)) begin
                        link.cfgReset <= 1'b0; // [RULE_08]
                        waitCnt_q     <= 8'h00;
                        state_q       <= H_WAIT;
                    end
                end
                // No frame before the device has settled
                H_WAIT: begin
                    waitCnt_q <= waitCnt_q + 8'h01;
                    if (waitCnt_q == 8'(RST_WAIT_CYC - 1)) begin
                        reqReady <= 1'b1; // [RULE_08]
                        state_q  <= H_IDLE;
                    end
                end
                // Take a request, open the frame with the direction bit
                H_IDLE: begin
                    if (reqValid) begin
                        reqReady      <= 1'b0;
                        isRead_q      <= reqRead;
                        txShift_q     <= {reqRead ? DIR_READ : DIR_WRITE, reqAddr,
                                          reqData}; // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
                        link.hostDio  <= reqRead ? DIR_READ : DIR_WRITE; // [RULE_09]
                        link.hostDioOe<= 1'b1; // [RULE_06]
                        link.csN      <= 1'b0; // [RULE_09]
                        half_q        <= 6'h00;
                        state_q       <= H_SETUP;
                    end
                end
                // Setup half period before the first rise
                H_SETUP: begin
                    if (tick) begin
                        state_q <= H_SHIFT;
                    end
                end
                // Even halves raise the clock, odd halves lower it
                H_SHIFT: begin
                    if (tick) begin
                        half_q <= half_q + 6'h01;
                        if (!half_q[0]) begin
                            link.sclk <= 1'b1;
                            if (half_q >= HALF_READ_FROM) begin
                                rxShift_q <= {rxShift_q[DATA_BITS-2:0], readBit};
                            end
                        end else begin
                            link.sclk <= 1'b0;
                            txShift_q <= {txShift_q[FRAME_BITS-2:0], 1'b0};
                            link.hostDio <= txShift_q[FRAME_BITS-2]; // [RULE_09]
                            if (half_q == HALF_HEAD_FALL && isRead_q) begin
                                link.hostDioOe <= 1'b0; // [RULE_06]
                            end
                            if (half_q == HALF_LAST) begin
                                link.hostDioOe <= 1'b0;
                                state_q        <= H_HOLD;
                            end
                        end
                    end
                end
                // Close the frame and report a read byte
                H_HOLD: begin
                    if (tick) begin
                        link.csN <= 1'b1;
                        reqReady <= 1'b1;
                        rspValid <= isRead_q;
                        rspData  <= rxShift_q;
                        state_q  <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_RESET;
                end
            endcase
        end
    end

endmodule

// file: hw/spi_cfg_link.sv
// Interface joining the host end and the device end of the configuration port
`timescale 1ns/1ns
interface spi_cfg_link;
    logic csN;         // Frame select, active low
    logic sclk;        // Serial clock from the host
    logic hostDio;     // Host value for the shared data pin
    logic hostDioOe;   // Host drives the shared data pin
    logic devDio;      // Device value for the shared data pin
    logic devDioOe;    // Device drives the shared data pin
    logic sdo;         // Dedicated device output pin
    logic cfgReset;    // Device reset pulse from the host
    logic dioLevel;    // Resolved level of the shared pin

    // Wire resolution with a pull-up when nobody drives
    assign dioLevel = hostDioOe ? hostDio : (devDioOe ? devDio : 1'b1);

    modport host_mp (
        output csN, sclk, hostDio, hostDioOe, cfgReset,
        input  dioLevel, sdo
    );
    modport dev_mp (
        input  csN, sclk, dioLevel, cfgReset,
        output devDio, devDioOe, sdo
    );
endinterface

// file: hw/spi_cfg_pkg.sv
// Shared constants and types for the serial configuration port
package spi_cfg_pkg;

    // Frame layout, most significant bit first
    localparam int FRAME_BITS   = 24;            // Whole frame length
    localparam int HEAD_BITS    = 16;            // Direction plus address
    localparam int ADDR_BITS    = 15;            // Register address width
    localparam int DATA_BITS    = 8;             // Register data width
    localparam int DIR_POS      = 23;            // Direction bit position in frame
    localparam logic DIR_READ   = 1'b1;          // Direction code for a read
    localparam logic DIR_WRITE  = 1'b0;          // Direction code for a write

    // Register storage inside the device end
    localparam int NUM_REGS     = 16;            // Implemented registers
    localparam int REG_IDX_BITS = 4;             // Index width of the storage
    localparam logic [7:0] REG_RESET = 8'h00;    // Reset value of each register

    // Frame bit counter, counts sampled bits
    localparam logic [4:0] CNT_HEAD_DONE  = 5'h10; // Header fully received
    localparam logic [4:0] CNT_LAST_BIT   = 5'h17; // Count before the final bit
    localparam logic [4:0] CNT_FRAME_DONE = 5'h18; // All bits received

    // Host half-period counter over one frame
    localparam logic [5:0] HALF_HEAD_FALL = 6'h1F; // Fall after the 16th rise
    localparam logic [5:0] HALF_LAST      = 6'h2F; // Final falling half
    localparam logic [5:0] HALF_READ_FROM = 6'h20; // First rise of read data

    // Timing at the 100 MHz reference clock
    localparam int CLK_PERIOD_NS = 10;           // Reference clock period
    localparam int SCLK_HALF_NS  = 50;           // Serial clock half period
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_PULSE_NS  = 100;          // Device reset pulse width
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_WAIT_NS   = 1000;         // Wait after the reset pulse
    localparam int RST_WAIT_CYC  = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host sequencer states, one-hot
    typedef enum logic [5:0] {
        H_RESET = 6'h01,   // Driving the device reset pulse
        H_WAIT  = 6'h02,   // Letting the device settle
        H_IDLE  = 6'h04,   // Ready for a request
        H_SETUP = 6'h08,   // Select low, first bit on the pin
        H_SHIFT = 6'h10,   // Clocking the 24 bits
        H_HOLD  = 6'h20    // Select release after the last bit
    } host_state_type;

endpackage

// file: test/spi_cfg_assertions.sv
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ns
module spi_cfg_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Wiring option
    input wire logic threeWire,
    // Link signals
    input wire logic csN,
    input wire logic sclk,
    input wire logic hostDio,
    input wire logic hostDioOe,
    input wire logic devDio,
    input wire logic devDioOe,
    input wire logic sdo,
    input wire logic cfgReset,
    input wire logic dioLevel
);
    ////////////////////////////////////////////////////////////////////////////////
    logic       sclkPrev_q;  // Serial clock one cycle ago
    logic [4:0] riseCnt_q;   // Serial clock rises seen in the current frame

    // Remember the serial clock to find its rising edges
    always_ff @(posedge ref_clk) begin
        sclkPrev_q <= reset ? 1'b0 : sclk;
    end

    // Count rises while the frame is selected, clear between frames
    always_ff @(posedge ref_clk) begin
        if (reset || csN) begin
            riseCnt_q <= 5'h00;
        end else if (sclk && !sclkPrev_q) begin
            riseCnt_q <= riseCnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    pin_exclusive_a: assert property (!(hostDioOe && devDioOe))
        else $error("both ends drive the shared pin");
    dev_mode_a: assert property (devDioOe |-> threeWire)
        else $error("device drives shared pin in four-wire mode");
    dev_release_a: assert property (csN && $past(csN) |-> !devDioOe)
        else $error("device drives shared pin outside a frame");
    sclk_idle_a: assert property (csN |-> !sclk)
        else $error("serial clock high while deselected");
    sclk_half_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
        else $error("serial clock high phase has wrong length");
    frame_length_a: assert property ($rose(csN) |-> riseCnt_q == 5'h18)
        else $error("frame did not carry 24 clock rises");
    read_start_a: assert property ($rose(devDioOe) |->
        riseCnt_q == 5'h10 && $past(hostDioOe) == 1'b0)
        else $error("device began driving at the wrong bit");
    read_end_a: assert property ($fell(devDioOe) |-> riseCnt_q >= 5'h17 || csN)
        else $error("device released shared pin early");
    host_head_a: assert property ($fell(hostDioOe) && !csN |-> riseCnt_q == 5'h10 || riseCnt_q == 5'h18)
        else $error("host released shared pin at the wrong bit");
    reset_first_a: assert property (!csN |-> !cfgReset)
        else $error("frame started while device reset active");
endmodule

// file: test/spi_config_port_test.sv
// Self-checking bench for both ends joined by their link
`timescale 1ns/1ns
module spi_config_port_test
    import spi_cfg_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int TIMEOUT = 6000;            // Cycle ceiling for the whole run
    logic                          ref_clk;   // Reference clock
    logic                          reset;     // Synchronous reset
    logic                          threeWire; // Wiring option for both ends
    logic                          reqValid;  // Host request
    logic                          reqRead;   // Host request direction
    logic [ADDR_BITS-1:0]          reqAddr;   // Host request address
    logic [DATA_BITS-1:0]          reqData;   // Host request write byte
    logic                          reqReady;  // Host idle
    logic                          rspValid;  // Read answer strobe
    logic [DATA_BITS-1:0]          rspData;   // Read answer byte
    logic [NUM_REGS*DATA_BITS-1:0] regFlat;   // Device register contents
    logic [NUM_REGS*DATA_BITS-1:0] expRegs = '0; // Bench register model
    logic                          wrPulse;   // Device write strobe
    logic [ADDR_BITS-1:0]          wrAddr;    // Device write address
    logic [DATA_BITS-1:0]          wrData;    // Device write byte
    logic [23:0]                   frameBits; // Shared pin levels at each rise
    logic [7:0]                    sdoBits;   // Dedicated output levels at each rise
    int                            bitCnt;    // Rises seen in the last frame
    int errCount = 0;                         // Mismatches
    int checkCount = 0;                       // Comparisons made
    int cycleCount = 0;                       // Cycles since start

    ////////////////////////////////////////////////////////////////////////////////
    spi_cfg_link spi_cfg_link_inst ();
    spi_cfg_host spi_cfg_host_inst (.ref_clk(ref_clk), .reset(reset), .threeWire(threeWire),
        .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .link(spi_cfg_link_inst));
    spi_cfg_device spi_cfg_device_inst (.ref_clk(ref_clk), .reset(reset), .threeWire(threeWire),
        .regFlat(regFlat), .wrPulse(wrPulse), .wrAddr(wrAddr), .wrData(wrData),
        .link(spi_cfg_link_inst));
    spi_cfg_assertions spi_cfg_assertions_inst (.ref_clk(ref_clk), .reset(reset),
        .threeWire(threeWire), .csN(spi_cfg_link_inst.csN), .sclk(spi_cfg_link_inst.sclk),
        .hostDio(spi_cfg_link_inst.hostDio), .hostDioOe(spi_cfg_link_inst.hostDioOe),
        .devDio(spi_cfg_link_inst.devDio), .devDioOe(spi_cfg_link_inst.devDioOe),
        .sdo(spi_cfg_link_inst.sdo), .cfgReset(spi_cfg_link_inst.cfgReset),
        .dioLevel(spi_cfg_link_inst.dioLevel));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generator
    always #5 ref_clk = ~ref_clk;

    // Wire monitor: restart at frame select, shift both data pins at each rise
    always @(negedge spi_cfg_link_inst.csN) bitCnt = 0;
    always @(posedge spi_cfg_link_inst.sclk) begin
        if (spi_cfg_link_inst.csN === 1'b0) begin
            frameBits = {frameBits[22:0], spi_cfg_link_inst.dioLevel};
            sdoBits = {sdoBits[6:0], spi_cfg_link_inst.sdo};
            bitCnt++;
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycleCount++;
        if (cycleCount == TIMEOUT) begin
            errCount++;
            $display("CHECK FAILED run length expected below %0d cycles", TIMEOUT);
            giveVerdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count the result
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // One host request, then judge the wire frame, the answer and the registers
    task automatic doReq(input logic rd, input logic [ADDR_BITS-1:0] addr,
                         input logic [DATA_BITS-1:0] dat, input logic [DATA_BITS-1:0] expRd);
        int                            n;
        logic                          gotRsp;
        logic                          gotWr;
        n = 0;
        gotRsp = 1'b0;
        gotWr = 1'b0;
        while (reqReady !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        reqValid = 1'b1;
        reqRead = rd;
        reqAddr = addr;
        reqData = dat;
        @(negedge ref_clk);
        reqValid = 1'b0;
        n = 0;
        while (reqReady !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            gotRsp = gotRsp | (rspValid === 1'b1);
            gotWr = gotWr | (wrPulse === 1'b1);
            n++;
        end
        check("frame completes", n < 400, 1);
        check("bits per frame", bitCnt, 24);
        check("wire frame", frameBits, {rd, addr, rd ? (threeWire ? expRd : 8'hFF) : dat});
        if (rd) begin
            check("read strobe", gotRsp, 1);
            check("read byte", rspData, expRd);
            if (!threeWire) check("output pin byte", sdoBits, expRd);
        end else begin
            check("write strobe", gotWr, addr < NUM_REGS);
            if (addr < NUM_REGS) begin
                expRegs[{addr[3:0], 3'b000} +: 8] = dat;
                check("write address", wrAddr, addr);
                check("write byte", wrData, dat);
            end
        end
        check("register contents", regFlat, expRegs);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Registers clear and the host holds off until the device reset settles
    task automatic resetTest();
        int n;
        n = 0;
        check("registers after reset", regFlat, 0);
        while (reqReady !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check("settle before ready", n >= RST_PULSE_CYC + RST_WAIT_CYC, 1);
        $display("Reset test finished");
    endtask

    // Back-to-back writes at both ends of storage, then writes beyond it
    task automatic writeTest();
        doReq(DIR_WRITE, 15'h0000, 8'hA5, 8'h00);
        doReq(DIR_WRITE, 15'h000F, 8'h3C, 8'h00);
        doReq(DIR_WRITE, 15'h0010, 8'hFF, 8'h00);
        doReq(DIR_WRITE, 15'h4003, 8'h77, 8'h00);
        $display("Write test finished");
    endtask

    // Reads on the shared pin, including unimplemented and untouched places
    task automatic readTest();
        doReq(DIR_READ, 15'h000F, 8'h00, 8'h3C);
        doReq(DIR_READ, 15'h0000, 8'h00, 8'hA5);
        doReq(DIR_READ, 15'h0010, 8'h00, 8'h00);
        doReq(DIR_READ, 15'h0003, 8'h00, 8'h00);
        $display("Three-wire read test finished");
    endtask

    // Four-wire option: read byte on the dedicated pin, shared pin left pulled up
    task automatic fourWireTest();
        threeWire = 1'b0;
        doReq(DIR_WRITE, 15'h0005, 8'h81, 8'h00);
        doReq(DIR_READ, 15'h0005, 8'h00, 8'h81);
        doReq(DIR_READ, 15'h000F, 8'h00, 8'h3C);
        threeWire = 1'b1;
        $display("Four-wire test finished");
    endtask

    // Print the counts and the verdict, then stop
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        threeWire = 1'b1;
        reqValid = 1'b0;
        reqRead = 1'b0;
        reqAddr = 15'h0000;
        reqData = 8'h00;
        repeat (4) @(negedge ref_clk);
        reset = 1'b0;
        resetTest();
        writeTest();
        readTest();
        fourWireTest();
        giveVerdict();
    end
endmodule
